// ===== rtl/sync_serial_cfg.svh
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH
// Register byte offsets
`define OFS_CHANNEL_MODE 8'h00
`define OFS_CHANNEL_CTRL0 8'h04
`define OFS_CHANNEL_CTRL1 8'h08
`define OFS_SHARED_CTRL 8'h0C
`define OFS_TRANSMIT_BUF 8'h10
`define OFS_RECEIVE_BUF 8'h14
// channel_mode_register fields
`define MODE_FIELD_MSB 2
`define MODE_CLKSRC_BIT 3
`define MODE_DISABLED 3'h0
`define MODE_CLOCK_SYNC 3'h1
// channel_control_0 fields
`define C0_FLOW_DIS_BIT 0
`define C0_FLOW_DIR_BIT 1
`define C0_OPEN_DRAIN_BIT 2
`define C0_POLARITY_BIT 3
`define C0_DIV_LSB 8
`define C0_DIV_MSB 15
`define C0_RESET 32'h0000_0001
// channel_control_1 fields
`define C1_TX_EN_BIT 0
`define C1_RX_EN_BIT 1
`define C1_TX_EMPTY_BIT 2
`define C1_RX_FULL_BIT 3
`define C1_BUSY_BIT 4
// shared_serial_control fields
`define SC_CLK_PIN_SEL_BIT 0
`define SC_MULTI_CLK_BIT 1
`define SC_SEP_CTS_BIT 2
`define SC_CH2_FLOW_DIS_BIT 3
`define SC_CH2_FLOW_DIR_BIT 4
`define SC_RESET 32'h0000_0008
// Index of the last bit of a frame
`define FRAME_BITS 3'h7
`endif

// ===== rtl/sync_serial_pkg.sv
package sync_serial_pkg;
	// Serial engine states, Gray along idle, shift, done
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE = 2'b11
	} xfer_state_e;
	// One pin driver: level and active low output enable
	typedef struct packed {
		logic out;
		logic oe_n;
	} pin_drive_s;
endpackage : sync_serial_pkg

// ===== rtl/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop #(
	parameter int WIDTH = 4
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;
	// Two stages; only the second stage is visible outside
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= '1;
			q <= '1;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : sync_two_flop

// ===== rtl/sync_serial_pin_select_recovery.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
module sync_serial_pin_select_recovery
	import sync_serial_pkg::*;
#(
	parameter bit FORCED_OPEN_DRAIN = 1'b0
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic receiveDataPin,
	input wire logic transferClockPinIn,
	input wire logic flowPinIn,
	input wire logic sharedPortPinIn,
	input wire logic ch2RtsLevel,
	output logic ch2CtsLevel,
	output pin_drive_s transmitDataPin,
	output pin_drive_s transferClockPin,
	output pin_drive_s flowPin,
	output pin_drive_s sharedPortPin
);
	logic [3:0] modeReg;
	logic [31:0] ctrl0;
	logic [1:0] ctrl1;
	logic [31:0] sharedCtrl;
	logic [7:0] transmitBuffer;
	logic [7:0] receiveBuffer;
	logic txFull, rxFull, started, txdLevel, sclk, lastSclk;
	logic [7:0] txShift, rxShift;
	logic [7:0] divCnt;
	logic [2:0] bitCnt;
	xfer_state_e state, next_state;
	logic [3:0] pinSync;

	// Pin inputs into the clock domain
	sync_two_flop #(.WIDTH(4)) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.d({sharedPortPinIn, flowPinIn, transferClockPinIn, receiveDataPin}),
		.q(pinSync)
	);

	// Register decode
	wire setupPh = psel && !penable;
	wire accessPh = psel && penable;
	wire hitMode = paddr == `OFS_CHANNEL_MODE;
	wire hitC0 = paddr == `OFS_CHANNEL_CTRL0;
	wire hitC1 = paddr == `OFS_CHANNEL_CTRL1;
	wire hitShared = paddr == `OFS_SHARED_CTRL;
	wire hitTx = paddr == `OFS_TRANSMIT_BUF;
	wire hitRx = paddr == `OFS_RECEIVE_BUF;
	wire mapped = hitMode | hitC0 | hitC1 | hitShared | hitTx | hitRx;
	wire wrEn = accessPh && pwrite && mapped;
	wire rdRx = accessPh && !pwrite && hitRx;
	assign pready = penable;
	assign pslverr = accessPh && !mapped;

	// Decoded control fields
	wire [2:0] modeField = modeReg[`MODE_FIELD_MSB:0];
	wire syncMode = modeField == `MODE_CLOCK_SYNC;
	wire modeOff = !syncMode;
	wire extClock = modeReg[`MODE_CLKSRC_BIT];
	wire flowDis = ctrl0[`C0_FLOW_DIS_BIT];
	wire flowRts = ctrl0[`C0_FLOW_DIR_BIT];
	wire polarity = ctrl0[`C0_POLARITY_BIT];
	wire openDrain = FORCED_OPEN_DRAIN | ctrl0[`C0_OPEN_DRAIN_BIT];
	wire [7:0] divLoad = ctrl0[`C0_DIV_MSB:`C0_DIV_LSB];
	wire txEn = ctrl1[`C1_TX_EN_BIT];
	wire rxEn = ctrl1[`C1_RX_EN_BIT];
	wire clkPinSel = sharedCtrl[`SC_CLK_PIN_SEL_BIT];
	wire multiClk = sharedCtrl[`SC_MULTI_CLK_BIT];
	wire sepCts = sharedCtrl[`SC_SEP_CTS_BIT];
	wire ch2FlowDis = sharedCtrl[`SC_CH2_FLOW_DIS_BIT];
	wire ch2FlowRts = sharedCtrl[`SC_CH2_FLOW_DIR_BIT];
	wire busy = state != ST_IDLE;

	// Clear-to-send source and transfer start condition
	wire ctsFromFlow = flowDis || flowRts || !pinSync[2];
	wire ctsOk = sepCts ? !pinSync[3] : ctsFromFlow;
	wire startXfer = syncMode && txEn && txFull && ctsOk && state == ST_IDLE;

	// Clock edge events, internal divider or synchronised pin
	wire tick = divCnt == 8'h00;
	wire intEdge = !extClock && state == ST_SHIFT && tick;
	wire fallEv = extClock ? (lastSclk && !pinSync[1]) : (intEdge && sclk);
	wire riseEv = extClock ? (!lastSclk && pinSync[1]) : (intEdge && !sclk);

	// Sequencing of one frame
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (startXfer) next_state = ST_SHIFT;
			ST_SHIFT: if (riseEv && bitCnt == `FRAME_BITS) next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
		if (modeOff) next_state = ST_IDLE;
	end

	// Next buffer flags
	wire next_txFull = modeOff ? 1'b0 : ((wrEn && hitTx) || (txFull && !startXfer));
	wire rxSet = state == ST_DONE && rxEn;
	wire next_rxFull = modeOff ? 1'b0 : (rxSet || (rxFull && !rdRx));

	// Read data mux, captured in the setup cycle
	wire [31:0] statusWord = {27'h0, busy, rxFull, !txFull, ctrl1};
	wire [31:0] readMux = hitMode ? {28'h0, modeReg} :
		hitC0 ? ctrl0 :
		hitC1 ? statusWord :
		hitShared ? sharedCtrl :
		hitRx ? {24'h0, receiveBuffer} : 32'h0;

	// Software registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			modeReg <= 4'h0;
			ctrl0 <= `C0_RESET;
			ctrl1 <= 2'h0;
			sharedCtrl <= `SC_RESET;
			transmitBuffer <= 8'h00;
			prdata <= 32'h0;
		end else begin
			if (wrEn && hitMode) modeReg <= pwdata[3:0];
			if (wrEn && hitC0) ctrl0 <= {16'h0, pwdata[15:8], 4'h0, pwdata[3:0]};
			if (wrEn && hitC1) ctrl1 <= pwdata[1:0];
			if (wrEn && hitShared) sharedCtrl <= {27'h0, pwdata[4:0]};
			if (wrEn && hitTx) transmitBuffer <= pwdata[7:0];
			if (setupPh) prdata <= readMux;
		end
	end

	// Buffer flags; a frame completing in a read cycle keeps the flag set
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txFull <= 1'b0;
			rxFull <= 1'b0;
			state <= ST_IDLE;
		end else begin
			txFull <= next_txFull;
			rxFull <= next_rxFull;
			state <= next_state;
		end
	end

	// Internal clock generation
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt <= 8'h00;
			sclk <= 1'b1;
		end else if (state != ST_SHIFT) begin
			divCnt <= divLoad;
			sclk <= 1'b1;
		end else if (tick) begin
			divCnt <= divLoad;
			sclk <= !sclk;
		end else begin
			divCnt <= divCnt - 8'h01;
		end
	end

	// Shifters: data out on falling edge, sampled on rising edge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txShift <= 8'h00;
			rxShift <= 8'h00;
			bitCnt <= 3'h0;
			txdLevel <= 1'b1;
			started <= 1'b0;
			lastSclk <= 1'b1;
			receiveBuffer <= 8'h00;
		end else begin
			lastSclk <= pinSync[1];
			if (modeOff) begin
				started <= 1'b0;
				txdLevel <= 1'b1;
				bitCnt <= 3'h0;
			end else if (startXfer) begin
				txShift <= transmitBuffer;
				bitCnt <= 3'h0;
			end else if (state == ST_SHIFT && fallEv) begin
				txdLevel <= txShift[0];
				started <= 1'b1;
			end else if (state == ST_SHIFT && riseEv) begin
				rxShift <= {pinSync[0], rxShift[7:1]};
				txShift <= {1'b1, txShift[7:1]};
				bitCnt <= bitCnt + 3'h1;
			end
			if (rxSet) receiveBuffer <= rxShift;
		end
	end

	// Data pin: high or released before the first frame, open-drain floats ones
	wire txdHigh = !started || txdLevel;
	always_comb begin
		transmitDataPin.out = txdHigh;
		transmitDataPin.oe_n = !syncMode || (openDrain && txdHigh);
	end

	// Clock routing between the clock pin and the shared pin
	wire staticLevel = !polarity;
	wire clkOnShared = multiClk && clkPinSel;
	wire intClkOut = !extClock && syncMode;
	always_comb begin
		transferClockPin.out = clkOnShared ? staticLevel : sclk;
		transferClockPin.oe_n = !intClkOut;
		sharedPortPin.out = 1'b1;
		sharedPortPin.oe_n = 1'b1;
		if (multiClk) begin
			sharedPortPin.out = clkPinSel ? sclk : staticLevel;
			sharedPortPin.oe_n = !syncMode;
		end else if (!ch2FlowDis && ch2FlowRts) begin
			sharedPortPin.out = ch2RtsLevel;
			sharedPortPin.oe_n = 1'b0;
		end
	end

	// Flow pin: port, CTS input or RTS output low while ready
	wire rtsLevel = !(rxEn && !rxFull && !busy);
	always_comb begin
		flowPin.out = rtsLevel;
		flowPin.oe_n = !(syncMode && !flowDis && flowRts);
	end

	// Second channel's CTS seen through the shared pin
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ch2CtsLevel <= 1'b1;
		end else begin
			ch2CtsLevel <= pinSync[3];
		end
	end
endmodule : sync_serial_pin_select_recovery

// ===== bench/sync_serial_pin_checker.sv
`timescale 1ns/1ps
module sync_serial_pin_checker
	import sync_serial_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire pin_drive_s transmitDataPin,
	input wire pin_drive_s transferClockPin,
	input wire pin_drive_s flowPin,
	input wire pin_drive_s sharedPortPin
);
	logic [3:0] md;
	logic [3:0] c0;
	logic [1:0] sc;
	logic sent;
	wire wr = psel && penable && pwrite;
	wire on = md[2:0] == 3'h1;
	// Shadow of the pin settings; sent marks a transfer since selection
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			md <= 4'h0;
			c0 <= 4'h1;
			sc <= 2'h0;
			sent <= 1'b0;
		end else if (wr) begin
			if (paddr == 8'h00) md <= pwdata[3:0];
			if (paddr == 8'h04) c0 <= pwdata[3:0];
			if (paddr == 8'h0C) sc <= pwdata[1:0];
			if (paddr == 8'h10) sent <= 1'b1;
			if (paddr == 8'h00 && pwdata[2:0] != 3'h1) sent <= 1'b0;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	idle_high_a: assert property (on && !sent && !c0[2] |->
		transmitDataPin == 2'b10) else $error("data pin not idle high");
	idle_float_a: assert property (on && !sent && c0[2] |->
		transmitDataPin.oe_n) else $error("data pin not released");
	drain_low_a: assert property (c0[2] && !transmitDataPin.oe_n |->
		!transmitDataPin.out) else $error("open drain drove high");
	flow_port_a: assert property (on && (c0[0] || !c0[1]) |->
		flowPin.oe_n) else $error("flow pin driven");
	rts_out_a: assert property (on && c0[1:0] == 2'b10 |->
		!flowPin.oe_n) else $error("flow pin not driven");
	clk_dir_a: assert property (on |->
		transferClockPin.oe_n == md[3]) else $error("clock pin direction");
	off_quiet_a: assert property (!on |-> transmitDataPin.oe_n &&
		transferClockPin.oe_n && flowPin.oe_n) else $error("pins driven off");
	static_lvl_a: assert property (on && !md[3] && sc == 2'b10 |->
		sharedPortPin == {!c0[3], 1'b0}) else $error("static level");
	shared_clk_a: assert property (on && !md[3] && sc == 2'b11 |->
		!sharedPortPin.oe_n && transferClockPin.out == !c0[3])
		else $error("second clock pin");
	cover property (on && sent && md[3]);
	cover property (sc == 2'b11 && $fell(sharedPortPin.out));
	cover property (on && c0[1:0] == 2'b10 && sent);
endmodule : sync_serial_pin_checker
bind sync_serial_pin_select_recovery sync_serial_pin_checker i_chk (
	.ref_clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata,
	.transmitDataPin, .transferClockPin, .flowPin, .sharedPortPin);

// ===== bench/serial_peer_model.sv
`timescale 1ns/1ps
module serial_peer_model (
	input wire logic lineClk,
	input wire logic devTxd,
	output logic peerClk,
	output logic peerTxd,
	output logic [7:0] seen
);
	logic [7:0] sendByte;
	int nFall;
	initial begin
		peerClk = 1'b1;
		peerTxd = 1'b1;
		seen = 8'h00;
		sendByte = 8'h00;
		nFall = 8;
	end
	// Load the byte returned in the next frame
	task automatic arm(input logic [7:0] b);
		sendByte = b;
		nFall = 0;
	endtask : arm
	// Our own clock for one frame; stands high between frames
	task automatic frame;
		repeat (8) begin
			#80 peerClk = 1'b0;
			#80 peerClk = 1'b1;
		end
	endtask : frame
	// Bits change on falls; past the frame the line scrambles
	always @(negedge lineClk) begin
		peerTxd <= (nFall < 8) ? sendByte[nFall[2:0]] : !peerTxd;
		nFall <= nFall + 1;
	end
	// Device data captured LSB first on rises
	always @(posedge lineClk) seen <= {devTxd, seen[7:1]};
endmodule : serial_peer_model

// ===== bench/sync_serial_pin_select_recovery_tb_top.sv
`timescale 1ns/1ps
module sync_serial_pin_select_recovery_tb_top;
	import sync_serial_pkg::*;
	logic ref_clk, reset_n, psel, penable, pwrite, lastErr;
	logic flowPinIn, sharedPortPinIn, ch2RtsLevel;
	logic [7:0] paddr;
	logic [31:0] pwdata, q, prdata;
	logic pready, pslverr, ch2CtsLevel;
	pin_drive_s transmitDataPin, transferClockPin, flowPin, sharedPortPin;
	wire logic peerClk, receiveDataPin;
	wire logic [7:0] seen;
	wire logic transferClockPinIn = transferClockPin.oe_n ? peerClk
		: transferClockPin.out;
	wire logic txLine = transmitDataPin.oe_n | transmitDataPin.out;
	int err_total, n_tests, cyc, nSh;
	sync_serial_pin_select_recovery i_dut (.ref_clk, .reset_n, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.receiveDataPin, .transferClockPinIn, .flowPinIn, .sharedPortPinIn,
		.ch2RtsLevel, .ch2CtsLevel, .transmitDataPin, .transferClockPin,
		.flowPin, .sharedPortPin);
	serial_peer_model i_peer (.lineClk(transferClockPinIn), .devTxd(txLine),
		.peerClk, .peerTxd(receiveDataPin), .seen);
	task automatic tally_and_finish;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string s, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// One APB transfer, held until pready
	task automatic bus(input logic w, input logic [7:0] a, input int d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk); // Outputs of the write settle before callers look
	endtask : bus
	task automatic xfer(input logic [7:0] t, r, input logic ext);
		i_peer.arm(r);
		bus(1, 8'h10, t);
		if (ext) begin
			@(negedge ref_clk); // Peer edges stay off the sampling edge
			i_peer.frame();
		end
	endtask : xfer
	// Poll until idle with transmit buffer empty, then compare both ways
	task automatic fin(input logic [7:0] t, r);
		for (int i = 0; i < 100 && !(q[4] === 1'b0 && q[2] === 1'b1); i++)
			bus(0, 8'h08, 0);
		chk("txIdle", 32'h4, q & 32'h14);
		chk("peerSeen", 32'(t), 32'(seen));
		bus(0, 8'h14, 0);
		chk("rxBuf", 32'(r), q);
		q = 0;
	endtask : fin
	task automatic tRegs;
		bus(0, 8'h04, 0);
		chk("ctrl0", 32'h1, q);
		bus(0, 8'h0C, 0);
		chk("shared", 32'h8, q);
		bus(1, 8'h1C, 32'hFF);
		chk("slverr", 32'h1, 32'(lastErr));
		bus(0, 8'h1C, 0);
		chk("unmapped", 32'h0, q);
	endtask : tRegs
	task automatic tInternal;
		bus(1, 8'h04, 32'h0305);
		bus(1, 8'h00, 1);
		chk("odIdle", 32'h1, 32'(transmitDataPin.oe_n));
		bus(1, 8'h04, 32'h0301);
		chk("idle", 32'h2, 32'(transmitDataPin));
		bus(1, 8'h08, 3);
		xfer(8'h3C, 8'hA5, 0);
		fin(8'h3C, 8'hA5);
		bus(1, 8'h00, 32'h9);
		chk("ckIn", 32'h1, 32'(transferClockPin.oe_n));
		xfer(8'h00, 8'h5A, 1);
		fin(8'h00, 8'h5A);
	endtask : tInternal
	// Transfer held by a high clear-to-send level, then released
	task automatic heldOff(input logic [31:0] c0, sc);
		bus(1, 8'h04, c0);
		bus(1, 8'h0C, sc);
		xfer(8'h66, 8'h11, 0);
		repeat (20) @(posedge ref_clk);
		bus(0, 8'h08, 0);
		chk("heldOff", 32'h0, 32'(q[2]));
		flowPinIn <= 1'b0;
		sharedPortPinIn <= 1'b0;
		fin(8'h66, 8'h11);
	endtask : heldOff
	task automatic tFlow;
		bus(1, 8'h00, 1);
		flowPinIn <= 1'b1;
		heldOff(32'h0300, 32'h08);
		sharedPortPinIn <= 1'b1;
		heldOff(32'h0302, 32'h04);
		ch2RtsLevel <= 1'b1;
		bus(1, 8'h0C, 32'h10);
		chk("ch2Rts", 32'h2, 32'(sharedPortPin));
		chk("ch2Cts", 32'h0, 32'(ch2CtsLevel));
	endtask : tFlow
	task automatic tMulti;
		bus(1, 8'h0C, 32'h0A);
		chk("staticHi", 32'h2, 32'(sharedPortPin));
		bus(1, 8'h04, 32'h0309);
		chk("staticLo", 32'h0, 32'(sharedPortPin));
		bus(1, 8'h04, 32'h0301);
		xfer(8'hC3, 8'h3C, 0);
		fin(8'hC3, 8'h3C);
		bus(1, 8'h0C, 32'h0B);
		nSh = 0;
		xfer(8'h81, 8'h00, 0);
		repeat (90) @(posedge ref_clk);
		chk("sharedFalls", 32'h8, nSh);
	endtask : tMulti
	// Abort mid-frame, then the buffer recovery sequences
	task automatic tRecover;
		bus(1, 8'h0C, 32'h08);
		xfer(8'h55, 8'h77, 0);
		repeat (20) @(posedge ref_clk);
		bus(1, 8'h08, 1);
		bus(1, 8'h00, 0);
		bus(0, 8'h08, 0);
		chk("cleared", 32'h5, q);
		bus(1, 8'h00, 1);
		bus(1, 8'h08, 3);
		xfer(8'h96, 8'h69, 0);
		fin(8'h96, 8'h69);
	endtask : tRecover
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = !ref_clk;
	end
	always @(negedge sharedPortPin.out) nSh++;
	// Cycle ceiling against a hang
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{flowPinIn, sharedPortPinIn, ch2RtsLevel} = '0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		tRegs();
		tInternal();
		tFlow();
		tMulti();
		tRecover();
		tally_and_finish();
	end
endmodule : sync_serial_pin_select_recovery_tb_top
